/* design/uart_rx_status_regs.vh */
// register offsets, field positions and reset values of the receive status block
`ifndef UART_RX_STATUS_REGS_VH
`define UART_RX_STATUS_REGS_VH

// ==========================================================
// register offsets
`define LS_MASK_ADDR      8'h03
`define LS_FLAGS_ADDR     8'h04
`define SC_MASK_ADDR      8'h05
`define SC_FLAGS_ADDR     8'h06

// ==========================================================
// widths and reset values
`define REG_W             8
`define FIELD_W           6
`define MASK_RESET        6'h00
`define FLAGS_RESET       6'h00
`define RDATA_RESET       8'h00
`define TAG_W             4

// ==========================================================
// line status fields
`define LS_CTS_BIT        7
`define LS_NOISE_BIT      5
`define LS_BREAK_BIT      4
`define LS_FRAME_BIT      3
`define LS_PARITY_BIT     2
`define LS_OVERRUN_BIT    1
`define LS_STALE_BIT      0

// ==========================================================
// per-character tag fields held in the tag queue
`define TAG_NOISE         3
`define TAG_BREAK         2
`define TAG_FRAME         1
`define TAG_PARITY        0

// ==========================================================
// special character fields
`define SC_ADDR_BIT       5
`define SC_BREAK_BIT      4
`define SC_MATCH_W        4
`define SC_MATCH_LSB      0

`endif

/* design/rx_tag_queue.v */
// per-character error tags kept in step with the receive queue
`timescale 1ns/1ps
module rx_tag_queue #(
    parameter WIDTH = 4,
    parameter DEPTH = 128,
    parameter AW    = 7
) (
    // clock and reset
    input  wire             clk_i,
    input  wire             reset_n_i,
    // fill side
    input  wire             push_i,
    input  wire [WIDTH-1:0] tag_i,
    // drain side
    input  wire             pop_i,
    output wire [WIDTH-1:0] tag_o,
    // level
    output wire             full_o,
    output wire             empty_o
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_ff;
    reg [AW-1:0]    rd_ptr_ff;
    reg [AW:0]      count_ff;
    wire            do_push;
    wire            do_pop;

    // a full queue refuses the newcomer even if a pop lands in the same cycle
    assign full_o  = (count_ff == DEPTH[AW:0]);
    assign empty_o = (count_ff == {(AW+1){1'b0}});
    assign do_push = push_i & ~full_o;
    assign do_pop  = pop_i & ~empty_o;
    assign tag_o   = mem[rd_ptr_ff];

    always @(posedge clk_i) begin
        if (do_push) begin
            mem[wr_ptr_ff] <= tag_i;
        end
    end

    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_ptr_ff <= {AW{1'b0}};
            rd_ptr_ff <= {AW{1'b0}};
            count_ff  <= {(AW+1){1'b0}};
        end else begin
            if (do_push) begin
                wr_ptr_ff <= (wr_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_ff + 1'b1;
            end
            if (do_pop) begin
                rd_ptr_ff <= (rd_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_ff + 1'b1;
            end
            if (do_push & ~do_pop) begin
                count_ff <= count_ff + 1'b1;
            end else if (do_pop & ~do_push) begin
                count_ff <= count_ff - 1'b1;
            end
        end
    end
endmodule // rx_tag_queue

/* design/stale_timer.v */
// counts timeout units since the youngest character entered or one left
`timescale 1ns/1ps
module stale_timer #(
    parameter W = 8
) (
    // clock and reset
    input  wire         clk_i,
    input  wire         reset_n_i,
    // control
    input  wire [W-1:0] period_i,
    input  wire         restart_i,
    input  wire         armed_i,
    input  wire         tick_i,
    // result
    output reg          expire_o
);
    reg [W-1:0] cnt_ff;
    reg         done_ff;

    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_ff   <= {W{1'b0}};
            done_ff  <= 1'b0;
            expire_o <= 1'b0;
        end else begin
            expire_o <= 1'b0;
            if (restart_i) begin
                cnt_ff  <= {W{1'b0}};
                done_ff <= 1'b0;
            end else if (armed_i && tick_i && !done_ff && period_i != {W{1'b0}}) begin
                // fires once on the tick after the count has reached the period
                if (cnt_ff >= period_i) begin
                    done_ff  <= 1'b1;
                    expire_o <= 1'b1;
                end else begin
                    cnt_ff <= cnt_ff + 1'b1;
                end
            end
        end
    end
endmodule // stale_timer

/* design/uart_rx_status_interrupts.v */
// receive line status, special character flags and their summary bits
//
// Overview of operation
// - line mask bits 5..0 gate flags into summary0
// - error flags follow last read character, read-persistent
// - status bit 7 mirrors clear-to-send input live
// - noise during character tagged, shown in bit 5
// - break stores zero character tagged, bit 4
// - wrong stop bits tag framing error, bit 3
// - parity error bit 2; ninth bit in multidrop
// - arrival when full dropped, overrun bit 1 set
// - stale flag after period; zero period disables
// - stale timer restarts on push or pop
// - special mask bits 5..0 gate into summary1
// - special mask bits reset to zero
// - special flags clear on read; address bit 5
// - line break sets special bit 4
// - flow characters set bits 3..0 when detection enabled
// - summary0 sets on enabled line flag, clears on read
// - summary1 sets on enabled special flag, clears on read
// - multidrop mode disables receive parity checking
`timescale 1ns/1ps
`include "uart_rx_status_regs.vh"
module uart_rx_status_interrupts #(
    parameter DEPTH    = 128,
    parameter AW       = 7,
    parameter PERIOD_W = 8
) (
    // clock and reset
    input  wire                clk_i,
    input  wire                reset_n_i,
    // register bank access
    input  wire [7:0]          reg_addr_i,
    input  wire                reg_wr_i,
    input  wire                reg_rd_i,
    input  wire [7:0]          reg_wdata_i,
    output reg  [7:0]          reg_rdata_o,
    // receive holding register and main status reads
    input  wire                holding_rd_i,
    input  wire                main_status_rd_i,
    // receiver character events
    input  wire                rx_char_valid_i,
    input  wire                rx_noise_i,
    input  wire                rx_break_i,
    input  wire                rx_frame_err_i,
    input  wire                rx_parity_err_i,
    input  wire                rx_ninth_bit_i,
    input  wire [3:0]          rx_flow_match_i,
    // modem line and control settings
    input  wire                clear_to_send_i,
    input  wire                multidrop_en_i,
    input  wire                special_char_detect_en_i,
    input  wire [PERIOD_W-1:0] stale_period_i,
    input  wire                stale_tick_i,
    // summary bits toward the main status register
    output reg                 line_error_summary_o,
    output reg                 special_char_summary_o,
    // queue level
    output reg                 queue_full_o
);

    // ==========================================================
    // declarations
    reg  [`FIELD_W-1:0] line_status_irq_mask_ff;
    reg  [`FIELD_W-1:0] nxt_line_status_irq_mask;
    reg  [`FIELD_W-1:0] special_char_irq_mask_ff;
    reg  [`FIELD_W-1:0] nxt_special_char_irq_mask;
    reg  [`FIELD_W-1:0] special_char_irq_flags_ff;
    reg  [`FIELD_W-1:0] nxt_special_char_irq_flags;
    reg  [`TAG_W-1:0]   cur_tag_ff;
    reg  [`TAG_W-1:0]   nxt_cur_tag;
    reg                 overrun_flag_ff;
    reg                 nxt_overrun_flag;
    reg                 stale_data_flag_ff;
    reg                 nxt_stale_data_flag;
    reg  [7:0]          nxt_rdata;
    reg                 nxt_line_summary;
    reg                 nxt_special_summary;
    reg  [`FIELD_W-1:0] sc_set;
    reg  [`TAG_W-1:0]   push_tag;
    wire [`TAG_W-1:0]   head_tag;
    wire                q_full;
    wire                q_empty;
    wire                push;
    wire                pop;
    wire                stale_expire;
    wire [`FIELD_W-1:0] line_status_flags;
    wire                wr_ls_mask;
    wire                wr_sc_mask;
    wire                rd_ls_flags;
    wire                rd_sc_flags;
    wire [`FIELD_W-1:0] line_routed;
    wire [`FIELD_W-1:0] special_routed;
    genvar              gi;

    // ==========================================================
    // register decode
    assign wr_ls_mask  = reg_wr_i && (reg_addr_i == `LS_MASK_ADDR);
    assign wr_sc_mask  = reg_wr_i && (reg_addr_i == `SC_MASK_ADDR);
    assign rd_ls_flags = reg_rd_i && (reg_addr_i == `LS_FLAGS_ADDR);
    assign rd_sc_flags = reg_rd_i && (reg_addr_i == `SC_FLAGS_ADDR);

    // ==========================================================
    // character tags
    // a character arriving while the queue is full is not stored
    assign push = rx_char_valid_i & ~q_full;
    assign pop  = holding_rd_i & ~q_empty;

    always @* begin
        push_tag              = {`TAG_W{1'b0}};
        push_tag[`TAG_NOISE]  = rx_noise_i;
        push_tag[`TAG_BREAK]  = rx_break_i;
        push_tag[`TAG_FRAME]  = rx_frame_err_i;
        // multidrop carries the ninth bit instead of a parity check
        push_tag[`TAG_PARITY] = multidrop_en_i ? rx_ninth_bit_i : rx_parity_err_i;
    end

    rx_tag_queue #(
        .WIDTH (`TAG_W),
        .DEPTH (DEPTH),
        .AW    (AW)
    ) u_tag_queue (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .push_i    (push),
        .tag_i     (push_tag),
        .pop_i     (pop),
        .tag_o     (head_tag),
        .full_o    (q_full),
        .empty_o   (q_empty)
    );

    // the tags of the character just read out replace the old ones
    always @* begin
        nxt_cur_tag = cur_tag_ff;
        if (pop) begin
            nxt_cur_tag = head_tag;
        end
    end

    // ==========================================================
    // overrun
    always @* begin
        nxt_overrun_flag = overrun_flag_ff;
        // drop below maximum or status read clears, a new overrun wins
        if (rd_ls_flags || !q_full) begin
            nxt_overrun_flag = 1'b0;
        end
        if (rx_char_valid_i && q_full) begin
            nxt_overrun_flag = 1'b1;
        end
    end

    // ==========================================================
    // stale data
    stale_timer #(
        .W (PERIOD_W)
    ) u_stale_timer (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .period_i  (stale_period_i),
        .restart_i (push | pop),
        .armed_i   (~q_empty),
        .tick_i    (stale_tick_i),
        .expire_o  (stale_expire)
    );

    always @* begin
        nxt_stale_data_flag = stale_data_flag_ff;
        if (stale_expire) begin
            nxt_stale_data_flag = 1'b1;
        end
        // an expiry in the same cycle as a push or pop is overridden, the event clears the flag
        if (push || pop) begin
            nxt_stale_data_flag = 1'b0;
        end
        if (stale_period_i == {PERIOD_W{1'b0}}) begin
            nxt_stale_data_flag = 1'b0;
        end
    end

    // ==========================================================
    // line status view
    assign line_status_flags = {cur_tag_ff[`TAG_NOISE],
                                cur_tag_ff[`TAG_BREAK],
                                cur_tag_ff[`TAG_FRAME],
                                cur_tag_ff[`TAG_PARITY],
                                overrun_flag_ff,
                                stale_data_flag_ff};

    // ==========================================================
    // mask registers
    always @* begin
        nxt_line_status_irq_mask  = line_status_irq_mask_ff;
        nxt_special_char_irq_mask = special_char_irq_mask_ff;
        if (wr_ls_mask) begin
            nxt_line_status_irq_mask = reg_wdata_i[`FIELD_W-1:0];
        end
        if (wr_sc_mask) begin
            nxt_special_char_irq_mask = reg_wdata_i[`FIELD_W-1:0];
        end
    end

    // ==========================================================
    // special character flags
    always @* begin
        sc_set = {`FIELD_W{1'b0}};
        if (rx_char_valid_i) begin
            sc_set[`SC_ADDR_BIT] = multidrop_en_i & rx_ninth_bit_i;
            sc_set[`SC_BREAK_BIT] = rx_break_i;
            if (special_char_detect_en_i) begin
                sc_set[`SC_MATCH_LSB +: `SC_MATCH_W] = rx_flow_match_i;
            end
        end
    end

    always @* begin
        nxt_special_char_irq_flags = special_char_irq_flags_ff;
        if (rd_sc_flags) begin
            nxt_special_char_irq_flags = `FLAGS_RESET;
        end
        // an event in the reading cycle survives for the next read
        nxt_special_char_irq_flags = nxt_special_char_irq_flags | sc_set;
    end

    // ==========================================================
    // per-bit routing of flags through their enables
    generate
        for (gi = 0; gi < `FIELD_W; gi = gi + 1) begin : g_route
            // a clear enable keeps its flag out of the summary bit
            assign line_routed[gi]    = line_status_flags[gi] &
                                        line_status_irq_mask_ff[gi];
            assign special_routed[gi] = special_char_irq_flags_ff[gi] &
                                        special_char_irq_mask_ff[gi];
        end
    endgenerate

    // ==========================================================
    // summary bits
    always @* begin
        nxt_line_summary    = line_error_summary_o;
        nxt_special_summary = special_char_summary_o;
        if (main_status_rd_i) begin
            nxt_line_summary    = 1'b0;
            nxt_special_summary = 1'b0;
        end
        // a flag still standing sets the bit again, so set wins over read
        if (|line_routed) begin
            nxt_line_summary = 1'b1;
        end
        if (|special_routed) begin
            nxt_special_summary = 1'b1;
        end
    end

    // ==========================================================
    // read data
    always @* begin
        nxt_rdata = `RDATA_RESET;
        if (reg_rd_i) begin
            case (reg_addr_i)
                `LS_MASK_ADDR: begin
                    nxt_rdata[`FIELD_W-1:0] = line_status_irq_mask_ff;
                end
                `LS_FLAGS_ADDR: begin
                    nxt_rdata[`FIELD_W-1:0] = line_status_flags;
                    // sampled live, so the value after reset follows the pin
                    nxt_rdata[`LS_CTS_BIT]  = clear_to_send_i;
                end
                `SC_MASK_ADDR: begin
                    nxt_rdata[`FIELD_W-1:0] = special_char_irq_mask_ff;
                end
                `SC_FLAGS_ADDR: begin
                    nxt_rdata[`FIELD_W-1:0] = special_char_irq_flags_ff;
                end
                default: begin
                    nxt_rdata = `RDATA_RESET;
                end
            endcase
        end
    end

    // ==========================================================
    // mask registers
    // masks change only on a host write, so they sit apart from the event flags
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            line_status_irq_mask_ff   <= `MASK_RESET;
            special_char_irq_mask_ff  <= `MASK_RESET;
        end else begin
            line_status_irq_mask_ff   <= nxt_line_status_irq_mask;
            special_char_irq_mask_ff  <= nxt_special_char_irq_mask;
        end
    end

    // ==========================================================
    // special character flags register
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            special_char_irq_flags_ff <= `FLAGS_RESET;
        end else begin
            special_char_irq_flags_ff <= nxt_special_char_irq_flags;
        end
    end

    // ==========================================================
    // line status registers
    // tags of the character in hand, plus the two queue-level flags
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cur_tag_ff                <= {`TAG_W{1'b0}};
            overrun_flag_ff           <= 1'b0;
            stale_data_flag_ff        <= 1'b0;
        end else begin
            cur_tag_ff                <= nxt_cur_tag;
            overrun_flag_ff           <= nxt_overrun_flag;
            stale_data_flag_ff        <= nxt_stale_data_flag;
        end
    end

    // ==========================================================
    // summary outputs
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            line_error_summary_o      <= 1'b0;
            special_char_summary_o    <= 1'b0;
        end else begin
            line_error_summary_o      <= nxt_line_summary;
            special_char_summary_o    <= nxt_special_summary;
        end
    end

    // ==========================================================
    // read data and queue level outputs
    // both registered so every port comes straight from a flop
    always @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            reg_rdata_o               <= `RDATA_RESET;
            queue_full_o              <= 1'b0;
        end else begin
            reg_rdata_o               <= nxt_rdata;
            queue_full_o              <= q_full;
        end
    end

endmodule // uart_rx_status_interrupts

/* dv/uart_rx_status_checker.sv */
// assertions on the ports of the receive status block
`timescale 1ns/1ps
module uart_rx_status_checker #(
    parameter PERIOD_W = 8
) (
    // clock and reset
    input wire                clk_i,
    input wire                reset_n_i,
    // register access
    input wire [7:0]          reg_addr_i,
    input wire                reg_wr_i,
    input wire                reg_rd_i,
    input wire [7:0]          reg_wdata_i,
    input wire [7:0]          reg_rdata_o,
    // character events and controls
    input wire                holding_rd_i,
    input wire                main_status_rd_i,
    input wire                rx_char_valid_i,
    input wire                rx_break_i,
    input wire                rx_ninth_bit_i,
    input wire [3:0]          rx_flow_match_i,
    input wire                clear_to_send_i,
    input wire                multidrop_en_i,
    input wire                special_char_detect_en_i,
    input wire [PERIOD_W-1:0] stale_period_i,
    // results
    input wire                line_error_summary_o,
    input wire                special_char_summary_o,
    input wire                queue_full_o
);
// ========
// reference copy of the special flags and their mask
wire      rd4 = reg_rd_i && reg_addr_i == 8'h04;
wire      rd6 = reg_rd_i && reg_addr_i == 8'h06;
reg [5:0] sc_ff;
reg [5:0] msk_ff;
always @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
        sc_ff  <= 6'h00;
        msk_ff <= 6'h00;
    end else begin
        // events in the reading cycle survive the clear
        sc_ff <= (rd6 ? 6'h00 : sc_ff) | (rx_char_valid_i ? {multidrop_en_i & rx_ninth_bit_i,
            rx_break_i, special_char_detect_en_i ? rx_flow_match_i : 4'h0} : 6'h00);
        if (reg_wr_i && reg_addr_i == 8'h05) begin
            msk_ff <= reg_wdata_i[5:0];
        end
    end
end
// ========
// properties
default clocking cb @(posedge clk_i); endclocking
default disable iff (!reset_n_i);
a_cts_live: assert property (rd4 |=> reg_rdata_o[7] == $past(clear_to_send_i))
    else $error("cts bit differs from input");
a_bit6_zero: assert property (reg_rd_i && reg_addr_i >= 8'h03 && reg_addr_i <= 8'h06
    |=> !reg_rdata_o[6]) else $error("bit 6 reads one");
a_mask_readback: assert property (reg_wr_i && reg_addr_i == 8'h03 ##1 !reg_wr_i
    ##1 reg_rd_i && reg_addr_i == 8'h03 |=> reg_rdata_o == ($past(reg_wdata_i, 3) & 8'h3F))
    else $error("line mask readback wrong");
a_special_flags: assert property (rd6 |=> reg_rdata_o == {2'b00, $past(sc_ff)})
    else $error("special flags wrong");
a_overrun_set: assert property (rx_char_valid_i && queue_full_o && !holding_rd_i
    && !$past(holding_rd_i) ##1 !rd4 && !holding_rd_i ##1 rd4 |=> reg_rdata_o[1])
    else $error("overrun not reported");
a_stale_off: assert property (rd4 && stale_period_i == 0 && $past(stale_period_i) == 0
    && $past(stale_period_i, 2) == 0 |=> !reg_rdata_o[0]) else $error("stale with zero period");
a_line_fall: assert property ($fell(line_error_summary_o) |-> $past(main_status_rd_i))
    else $error("line summary dropped without read");
a_special_rise: assert property ($rose(special_char_summary_o)
    |-> |($past(sc_ff) & $past(msk_ff))) else $error("special summary without cause");
endmodule // uart_rx_status_checker
bind uart_rx_status_interrupts uart_rx_status_checker #(.PERIOD_W(PERIOD_W))
    uart_rx_status_checker_i (.*);

/* dv/rx_char_source.sv */
// receiver model delivering characters and their tags
`timescale 1ns/1ps
module rx_char_source (
    // clock
    input  wire       clk_i,
    // character event
    output reg        valid_o,
    output reg  [8:0] tags_o
);
// ========
// t = {flow[3:0], ninth, noise, break, frame, parity}
initial begin
    valid_o = 1'b0;
    tags_o  = 9'h000;
end
task send(input [8:0] t, input integer gap);
    begin
        @(posedge clk_i);
        valid_o <= 1'b1;
        tags_o  <= t;
        @(posedge clk_i);
        valid_o <= 1'b0;
        // idle tags flip so a stale value never passes for fresh
        tags_o  <= ~t;
        repeat (gap) @(posedge clk_i);
    end
endtask
endmodule // rx_char_source

/* dv/uart_rx_status_interrupts_tb.sv */
// testbench for the receive status and interrupt block
`timescale 1ns/1ps
module uart_rx_status_interrupts_tb;
// ========
// signals
reg         clk_i;
reg         reset_n_i;
reg  [7:0]  reg_addr_i;
reg         reg_wr_i;
reg         reg_rd_i;
reg  [7:0]  reg_wdata_i;
wire [7:0]  reg_rdata_o;
reg         holding_rd_i;
reg         main_status_rd_i;
wire        rx_char_valid_i;
wire        rx_noise_i;
wire        rx_break_i;
wire        rx_frame_err_i;
wire        rx_parity_err_i;
wire        rx_ninth_bit_i;
wire [3:0]  rx_flow_match_i;
wire [8:0]  tg;
reg         clear_to_send_i;
reg         multidrop_en_i;
reg         special_char_detect_en_i;
reg  [7:0]  stale_period_i;
reg         stale_tick_i = 1'b0;
wire        line_error_summary_o;
wire        special_char_summary_o;
wire        queue_full_o;
integer     num_errors;
integer     checked;
integer     i;
reg  [15:0] r;
reg  [4:0]  t;
reg  [5:0]  sc;
reg  [7:0]  e [0:3];
assign {rx_flow_match_i, rx_ninth_bit_i, rx_noise_i, rx_break_i, rx_frame_err_i,
    rx_parity_err_i} = tg;
// short queue so overrun is reached quickly
uart_rx_status_interrupts #(.DEPTH(4), .AW(2), .PERIOD_W(8)) uart_rx_status_interrupts_i (.*);
rx_char_source rx_char_source_i (.clk_i(clk_i), .valid_o(rx_char_valid_i), .tags_o(tg));
// ========
// clock, tick and watchdog
initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
end
always @(posedge clk_i) stale_tick_i <= ~stale_tick_i;
initial begin
    #(4000 * 100);
    num_errors = num_errors + 1;
    end_sim;
end
// ========
// helpers
function [15:0] lfsr(input [15:0] x);
    lfsr = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
endfunction
function [7:0] ls_exp(input [4:0] c, input md);
    ls_exp = {2'b00, c[3:1], md ? c[4] : c[0], 2'b00};
endfunction
task chk(input [63:0] n, input [7:0] s, input [7:0] x);
    begin
        checked = checked + 1;
        if (s !== x) begin
            num_errors = num_errors + 1;
            $display("[ERR] %0s exp %h got %h", n, x, s);
        end
    end
endtask
task wr(input [7:0] a, input [7:0] w);
    begin
        @(posedge clk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= w;
        reg_wr_i    <= 1'b1;
        @(posedge clk_i);
        reg_wr_i    <= 1'b0;
    end
endtask
task rc(input [7:0] a, input [7:0] m, input [7:0] x);
    begin
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge clk_i);
        reg_rd_i   <= 1'b0;
        @(negedge clk_i);
        chk("rdata", reg_rdata_o & m, x);
    end
endtask
task pop;
    begin
        @(posedge clk_i);
        holding_rd_i <= 1'b1;
        @(posedge clk_i);
        holding_rd_i <= 1'b0;
        @(negedge clk_i);
    end
endtask
task ms;
    begin
        @(posedge clk_i);
        main_status_rd_i <= 1'b1;
        @(posedge clk_i);
        main_status_rd_i <= 1'b0;
        repeat (2) @(negedge clk_i);
    end
endtask
task end_sim;
    begin
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    end
endtask
// ========
// main sequence
initial begin
    num_errors = 0;
    checked = 0;
    r = 16'hBF26;
    sc = 6'h00;
    reset_n_i = 1'b0;
    reg_addr_i = 8'h00;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_wdata_i = 8'h00;
    holding_rd_i = 1'b0;
    main_status_rd_i = 1'b0;
    clear_to_send_i = 1'b1;
    multidrop_en_i = 1'b0;
    special_char_detect_en_i = 1'b0;
    stale_period_i = 8'h00;
    repeat (6) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rc(8'h03, 8'hFF, 8'h00);
    rc(8'h05, 8'hFF, 8'h00);
    wr(8'h03, 8'hFF);
    rc(8'h03, 8'hFF, 8'h3F);
    wr(8'h04, 8'hFF);
    wr(8'h05, 8'hC0);
    rc(8'h05, 8'hFF, 8'h00);
    rc(8'h07, 8'hFF, 8'h00);
    for (i = 0; i < 8; i = i + 1) begin
        r = lfsr(r);
        @(posedge clk_i);
        clear_to_send_i <= r[0];
        rc(8'h04, 8'hFF, {r[0], 7'h00});
    end
    // fill the queue, last one overruns
    for (i = 0; i < 5; i = i + 1) begin
        r = lfsr(r);
        t = (i == 4) ? 5'h00 : (r[4:0] | {1'b0, i == 3, 3'h0});
        @(posedge clk_i);
        multidrop_en_i <= r[9];
        rx_char_source_i.send({4'h0, t}, i % 4);
        if (i < 4) begin
            e[i] = ls_exp(t, r[9]);
            sc = sc | {r[9] & t[4], t[2], 4'h0};
        end
    end
    @(negedge clk_i);
    chk("full", {7'h00, queue_full_o}, 8'h01);
    rc(8'h04, 8'h02, 8'h02);
    rc(8'h04, 8'h02, 8'h00);
    wr(8'h03, 8'h3C);
    for (i = 0; i < 4; i = i + 1) begin
        pop;
        rc(8'h04, 8'h3C, e[i]);
        rc(8'h04, 8'h3C, e[i]);
        ms;
        chk("sum0", {7'h00, line_error_summary_o}, {7'h00, |e[i]});
    end
    wr(8'h03, 8'h00);
    rc(8'h06, 8'hFF, {2'b00, sc});
    rc(8'h06, 8'hFF, 8'h00);
    for (i = 0; i < 8; i = i + 1) begin
        @(posedge clk_i);
        special_char_detect_en_i <= i[0];
        wr(8'h05, 8'h01 << i[2:1]);
        rx_char_source_i.send({4'h1 << i[2:1], 5'h00}, 0);
        pop;
        chk("sum1", {7'h00, special_char_summary_o}, {7'h00, i[0]});
        rc(8'h06, 8'hFF, i[0] ? 8'h01 << i[2:1] : 8'h00);
        ms;
    end
    // pass 1 clears the stale flag by a push instead of a pop
    for (i = 0; i < 3; i = i + 1) begin
        @(posedge clk_i);
        stale_period_i <= (i == 2) ? 8'h00 : 8'h03;
        rx_char_source_i.send(9'h000, 20);
        rc(8'h04, 8'h01, {7'h00, i != 2});
        if (i == 1)
            rx_char_source_i.send(9'h000, 0);
        else
            pop;
        rc(8'h04, 8'h01, 8'h00);
    end
    end_sim;
end
endmodule // uart_rx_status_interrupts_tb
